// [core/esvo_pkg.sv]
// package for the encoder scaling and velocity output block
// assumes one clock domain shared with the fieldbus process data logic
package esvo_pkg;

  // ----------------------------------------
  // scaling limits and defaults
  // ----------------------------------------
  localparam logic [13:0] ESVO_SPR_MIN     = 14'h0002;
  localparam logic [13:0] ESVO_SPR_MAX     = 14'h2000;
  localparam logic [29:0] ESVO_RANGE_MIN   = 30'h0000_0004;
  localparam logic [29:0] ESVO_RANGE_MAX   = 30'h2000_0000;
  localparam int          ESVO_NATIVE_BITS = 13;
  localparam int          ESVO_RAW_W       = 29;

  // ----------------------------------------
  // sign-of-life and error codes
  // ----------------------------------------
  localparam logic [7:0]  ESVO_TOL_DEFAULT = 8'h01;
  localparam logic [15:0] ESVO_ERR_SOL     = 16'h0f02;

  // ----------------------------------------
  // control and status word bits
  // ----------------------------------------
  localparam int ESVO_BIT_PRESET_MODE = 11;
  localparam int ESVO_BIT_PRESET_EXEC = 12;
  localparam int ESVO_BIT_ERR_ACK     = 15;
  localparam int ESVO_BIT_ERR         = 15;
  localparam int ESVO_BIT_WARN        = 7;

  // ----------------------------------------
  // velocity units and normalisation
  // ----------------------------------------
  localparam logic [2:0]  ESVO_VU_STEPS_S   = 3'h0;
  localparam logic [2:0]  ESVO_VU_STEPS_100 = 3'h1;
  localparam logic [2:0]  ESVO_VU_STEPS_10  = 3'h2;
  localparam logic [2:0]  ESVO_VU_RPM       = 3'h3;
  localparam logic [2:0]  ESVO_VU_NORM      = 3'h4;
  localparam logic [31:0] ESVO_REF_DEFAULT  = 32'h453b_8000;
  localparam int          ESVO_N2_SHIFT     = 14;
  localparam int          ESVO_N4_SHIFT     = 30;
  localparam logic [63:0] ESVO_SEC_PER_MIN  = 64'h0000_0000_0000_003c;
  localparam logic [63:0] ESVO_DIV_100MS    = 64'h0000_0000_0000_000a;
  localparam logic [63:0] ESVO_DIV_10MS     = 64'h0000_0000_0000_0064;

  // ----------------------------------------
  // velocity filter
  // ----------------------------------------
  localparam logic [3:0]  ESVO_FILT_MAX    = 4'ha;
  localparam logic [31:0] ESVO_ACCEL_ENTER = 32'h0000_1000;
  localparam logic [31:0] ESVO_ACCEL_LEAVE = 32'h0000_0100;

  typedef enum logic [1:0] {
    ESVO_PS_IDLE = 2'b00,
    ESVO_PS_ACK  = 2'b01
  } esvo_preset_type;

  typedef struct packed {
    logic        class4_en;
    logic        scale_en;
    logic        dir_down;
    logic [13:0] steps_per_rev;
    logic [29:0] total_range;
    logic        compat_en;
    logic [7:0]  tol_faults;
    logic [2:0]  vel_unit;
    logic [3:0]  filt_level;
    logic        filt_dynamic;
    logic [31:0] ref_speed;
    logic [31:0] preset_value;
  } esvo_cfg_type;

endpackage : esvo_pkg

// [core/esvo_core.sv]
// position scaling, preset, sign-of-life supervision and velocity output
// assumes control word, parameters and raw sensor data come from logic on REF_CLK
`timescale 1ns/1ps
module esvo_core
  import esvo_pkg::*;
(
  // clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  // raw sensor data
  input  wire logic [ESVO_RAW_W-1:0] RAW_POSITION,
  input  wire logic signed [31:0]    RAW_VELOCITY,
  input  wire logic                  CYCLE_UPDATE,
  input  wire logic                  SOL_FAULT,
  // parameters and control
  input  wire esvo_pkg::esvo_cfg_type CFG,
  input  wire logic [15:0]           SENSOR_CONTROL_WORD,
  // process data out
  output logic [15:0]                SENSOR_STATUS_WORD,
  output logic [31:0]                POSITION_WORD_SECOND,
  output logic [15:0]                VELOCITY_WORD_SHORT,
  output logic [31:0]                VELOCITY_WORD_LONG,
  output logic                       PRESET_WARNING
);
  import esvo_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // float rpm to integer rpm; fractions are dropped, so references below 1 rpm read as 0
  function automatic logic [63:0] esvo_float_int(input logic [31:0] f);
    logic [63:0] mant;
    int          e;
    mant = {40'h0, 1'b1, f[22:0]};
    e    = int'(f[30:23]) - 127 - 23;
    if (f[31] || f[30:23] < 8'h7f)
      return 64'h0;
    else if (e >= 0)
      return (e > 39) ? 64'hffff_ffff : (mant << e);
    else
      return mant >> (-e);
  endfunction : esvo_float_int

  function automatic logic signed [63:0] esvo_sat(input logic signed [63:0] v,
                                                  input int                 w);
    logic signed [63:0] hi;
    hi = (64'sh1 <<< (w - 1)) - 64'sh1;
    if (v > hi)
      return hi;
    else if (v < -hi - 64'sh1)
      return -hi - 64'sh1;
    else
      return v;
  endfunction : esvo_sat

  // ----------------------------------------
  // state
  // ----------------------------------------
  esvo_cfg_type       cfg,        next_cfg;
  esvo_preset_type    pstate,     next_pstate;
  logic signed [33:0] offset,     next_offset;
  logic               prev_exec,  next_prev_exec;
  logic               prev_ack,   next_prev_ack;
  logic [8:0]         sol_count,  next_sol_count;
  logic               sol_error,  next_sol_error;
  logic               warn,       next_warn;
  logic               bypass,     next_bypass;
  logic signed [31:0] vel_filt,   next_vel_filt;
  logic [15:0]        status,     next_status;
  logic [31:0]        pos_out,    next_pos_out;
  logic [15:0]        vel_short,  next_vel_short;
  logic [31:0]        vel_long,   next_vel_long;

  logic [13:0]        spr;
  logic [29:0]        range;
  logic signed [33:0] scaled;
  logic signed [33:0] position;
  logic signed [31:0] vel_diff;
  logic [31:0]        vel_mag;
  logic signed [63:0] vel_unit;
  logic signed [63:0] denom;
  logic [7:0]         tol_limit;
  logic               exec_rise;

  // ----------------------------------------
  // combinational next state
  // ----------------------------------------
  always_comb
  begin
    next_cfg       = cfg;
    next_pstate    = pstate;
    next_offset    = offset;
    next_prev_exec = SENSOR_CONTROL_WORD[ESVO_BIT_PRESET_EXEC];
    next_prev_ack  = SENSOR_CONTROL_WORD[ESVO_BIT_ERR_ACK];
    next_sol_count = sol_count;
    next_sol_error = sol_error;
    next_warn      = warn;
    next_bypass    = bypass;
    next_vel_filt  = vel_filt;
    next_status    = status;
    next_pos_out   = pos_out;
    next_vel_short = vel_short;
    next_vel_long  = vel_long;

    // parameters are sampled at the update so words in flight never mix settings
    if (CYCLE_UPDATE)
      next_cfg = CFG;

    // out-of-limit steps per revolution and total range are clamped rather than refused, keeping the output defined
    if (cfg.class4_en && cfg.scale_en)
    begin
      spr   = (cfg.steps_per_rev < ESVO_SPR_MIN) ? ESVO_SPR_MIN :
              (cfg.steps_per_rev > ESVO_SPR_MAX) ? ESVO_SPR_MAX : cfg.steps_per_rev;
      range = (cfg.total_range < ESVO_RANGE_MIN) ? ESVO_RANGE_MIN :
              (cfg.total_range > ESVO_RANGE_MAX) ? ESVO_RANGE_MAX : cfg.total_range;
    end
    else
    begin
      spr   = ESVO_SPR_MAX;
      range = ESVO_RANGE_MAX;
    end

    // integer scaling: whole turns times steps, plus the scaled part turn
    scaled = 34'(({5'h0, RAW_POSITION} >> ESVO_NATIVE_BITS) * spr)
           + 34'((34'(RAW_POSITION[ESVO_NATIVE_BITS-1:0]) * spr) >> ESVO_NATIVE_BITS);
    if (cfg.dir_down)
      scaled = -scaled;
    position = (scaled + offset) % $signed({4'h0, range});
    if (position < 0)
      position = position + $signed({4'h0, range});

    // preset handshake
    exec_rise = SENSOR_CONTROL_WORD[ESVO_BIT_PRESET_EXEC] && !prev_exec;
    case (pstate)
      ESVO_PS_IDLE:
      begin
        if (exec_rise)
        begin
          if (SENSOR_CONTROL_WORD[ESVO_BIT_PRESET_MODE])
          begin
            next_offset = (offset + 34'($signed(cfg.preset_value)))
                        % $signed({4'h0, range});
            next_warn   = 1'b0;
            next_pstate = ESVO_PS_ACK;
          end
          else if ({2'h0, cfg.preset_value} < {4'h0, range})
          begin
            next_offset = (offset + $signed({2'h0, cfg.preset_value}) - position)
                        % $signed({4'h0, range});
            next_warn   = 1'b0;
            next_pstate = ESVO_PS_ACK;
          end
          else
            next_warn = 1'b1;
        end
      end
      ESVO_PS_ACK:
      begin
        if (!SENSOR_CONTROL_WORD[ESVO_BIT_PRESET_EXEC])
          next_pstate = ESVO_PS_IDLE;
      end
      default:
        next_pstate = ESVO_PS_IDLE;
    endcase

    // sign-of-life supervision; a fault in the ack cycle counts only if sol_count had not yet passed the tolerance
    tol_limit = cfg.compat_en ? cfg.tol_faults : ESVO_TOL_DEFAULT;
    if (SENSOR_CONTROL_WORD[ESVO_BIT_ERR_ACK] && !prev_ack)
    begin
      next_sol_count = 9'h0;
      next_sol_error = 1'b0;
    end
    if (SOL_FAULT && sol_count <= {1'b0, tol_limit})
      next_sol_count = next_sol_count + 9'h1;
    if (next_sol_count > {1'b0, tol_limit})
      next_sol_error = 1'b1;

    // velocity filter: first order, shift by intensity
    vel_diff = RAW_VELOCITY - vel_filt;
    vel_mag  = vel_diff[31] ? 32'(-vel_diff) : 32'(vel_diff);
    if (!cfg.filt_dynamic)
      next_bypass = 1'b0;
    else if (vel_mag > ESVO_ACCEL_ENTER)
      next_bypass = 1'b1;
    else if (vel_mag < ESVO_ACCEL_LEAVE)
      next_bypass = 1'b0;

    // velocity unit conversion
    denom = 64'(spr) * $signed(esvo_float_int(cfg.ref_speed));
    case (cfg.vel_unit)
      ESVO_VU_STEPS_S:   vel_unit = 64'(vel_filt);
      ESVO_VU_STEPS_100: vel_unit = 64'(vel_filt) / $signed(ESVO_DIV_100MS);
      ESVO_VU_STEPS_10:  vel_unit = 64'(vel_filt) / $signed(ESVO_DIV_10MS);
      ESVO_VU_NORM:      vel_unit = 64'(vel_filt) * $signed(ESVO_SEC_PER_MIN);
      default:           vel_unit = 64'(vel_filt) * $signed(ESVO_SEC_PER_MIN)
                                  / $signed(64'(spr));
    endcase

    if (CYCLE_UPDATE)
    begin
      if (cfg.filt_level == 4'h0 || cfg.filt_level > ESVO_FILT_MAX || next_bypass)
        next_vel_filt = RAW_VELOCITY;
      else
        next_vel_filt = vel_filt + (vel_diff >>> cfg.filt_level);
      next_pos_out = next_sol_error ? {16'h0, ESVO_ERR_SOL} : position[31:0];
      if (cfg.vel_unit == ESVO_VU_NORM && denom == 64'sh0)
      begin
        next_vel_short = 16'h0;
        next_vel_long  = 32'h0;
      end
      else if (cfg.vel_unit == ESVO_VU_NORM)
      begin
        next_vel_short = 16'(esvo_sat((vel_unit <<< ESVO_N2_SHIFT) / denom, 16));
        next_vel_long  = 32'(esvo_sat((vel_unit <<< ESVO_N4_SHIFT) / denom, 32));
      end
      else
      begin
        next_vel_short = 16'(esvo_sat(vel_unit, 16));
        next_vel_long  = 32'(esvo_sat(vel_unit, 32));
      end
    end

    next_status                       = 16'h0;
    next_status[ESVO_BIT_PRESET_EXEC] = (next_pstate == ESVO_PS_ACK);
    next_status[ESVO_BIT_ERR]         = next_sol_error;
    next_status[ESVO_BIT_WARN]        = next_warn;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg       <= '{class4_en: 1'b1, scale_en: 1'b0, dir_down: 1'b0,
                     steps_per_rev: ESVO_SPR_MAX, total_range: ESVO_RANGE_MAX,
                     compat_en: 1'b0, tol_faults: ESVO_TOL_DEFAULT,
                     vel_unit: ESVO_VU_RPM, filt_level: 4'h0, filt_dynamic: 1'b0,
                     ref_speed: ESVO_REF_DEFAULT, preset_value: 32'h0};
      pstate    <= ESVO_PS_IDLE;
      offset    <= 34'sh0;
      prev_exec <= 1'b0;
      prev_ack  <= 1'b0;
      sol_count <= 9'h0;
      sol_error <= 1'b0;
      warn      <= 1'b0;
      bypass    <= 1'b0;
      vel_filt  <= 32'sh0;
      status    <= 16'h0;
      pos_out   <= 32'h0;
      vel_short <= 16'h0;
      vel_long  <= 32'h0;
    end
    else
    begin
      cfg       <= next_cfg;
      pstate    <= next_pstate;
      offset    <= next_offset;
      prev_exec <= next_prev_exec;
      prev_ack  <= next_prev_ack;
      sol_count <= next_sol_count;
      sol_error <= next_sol_error;
      warn      <= next_warn;
      bypass    <= next_bypass;
      vel_filt  <= next_vel_filt;
      status    <= next_status;
      pos_out   <= next_pos_out;
      vel_short <= next_vel_short;
      vel_long  <= next_vel_long;
    end
  end

  assign SENSOR_STATUS_WORD   = status;
  assign POSITION_WORD_SECOND = pos_out;
  assign VELOCITY_WORD_SHORT  = vel_short;
  assign VELOCITY_WORD_LONG   = vel_long;
  assign PRESET_WARNING       = warn;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  preset_ack_rise_a: assert property (exec_rise && pstate == ESVO_PS_IDLE && !next_warn
    |=> status[ESVO_BIT_PRESET_EXEC]) else $error("preset not acknowledged");
  preset_ack_clear_a: assert property (pstate == ESVO_PS_ACK
    && !SENSOR_CONTROL_WORD[ESVO_BIT_PRESET_EXEC] |=> !status[ESVO_BIT_PRESET_EXEC])
    else $error("preset ack not cleared");
  sol_code_a: assert property (CYCLE_UPDATE && next_sol_error
    |=> pos_out == {16'h0, ESVO_ERR_SOL}) else $error("missing sign-of-life code");
  // the range of the update cycle itself, since cfg may be replaced on that same edge
  pos_in_range_a: assert property (CYCLE_UPDATE && !next_sol_error
    |=> pos_out < {2'h0, $past(range)}) else $error("position beyond range");
  words_hold_a: assert property (!CYCLE_UPDATE
    |=> $stable(pos_out) && $stable(vel_long) && $stable(vel_short))
    else $error("output changed between updates");
  filter_off_a: assert property (CYCLE_UPDATE && cfg.filt_level == 4'h0
    |=> vel_filt == $past(RAW_VELOCITY)) else $error("unfiltered velocity wrong");
  static_no_bypass_a: assert property (!cfg.filt_dynamic |=> !bypass)
    else $error("static filter bypassed");
  sol_tol_a: assert property (!cfg.compat_en && sol_count == 9'h0 && SOL_FAULT
    && !(SENSOR_CONTROL_WORD[ESVO_BIT_ERR_ACK] && !prev_ack) |=> !sol_error)
    else $error("first sign-of-life fault not tolerated");
  norm_zero_a: assert property (CYCLE_UPDATE && cfg.vel_unit == ESVO_VU_NORM
    && vel_filt == 32'sh0 |=> vel_short == 16'h0 && vel_long == 32'h0)
    else $error("zero speed not zero percent");

  preset_seen_c: cover property (exec_rise ##1 status[ESVO_BIT_PRESET_EXEC]);
  sol_error_c:   cover property (sol_error && CYCLE_UPDATE);
  bypass_c:      cover property (bypass ##[1:20] !bypass);
  norm_c:        cover property (CYCLE_UPDATE && cfg.vel_unit == ESVO_VU_NORM);

endmodule : esvo_core

// [bench/esvo_fieldbus_ctrl.sv]
// fieldbus controller model: drives the sensor control word
// assumes the bench shares the clock and calls the tasks between falling edges
`timescale 1ns/1ps
module esvo_fieldbus_ctrl
(
  // clock
  input  wire logic        ref_clk,
  // process data from the device
  input  wire logic [15:0] status_word,
  // process data to the device
  output logic [15:0]      control_word
);
  initial control_word = 16'h0000;

  // ----
  // preset handshake
  // ----
  // bit12 is held until the ack is seen or the bound runs out, never released early
  task automatic run_preset(input logic relative, output logic acked);
    int i;
    begin
      acked = 1'b0;
      @(negedge ref_clk);
      control_word[11] = relative;
      control_word[12] = 1'b0;
      @(negedge ref_clk);
      control_word[12] = 1'b1;
      for (i = 0; i < 8 && !acked; i++)
      begin
        @(negedge ref_clk);
        acked = (status_word[12] === 1'b1);
      end
      control_word[12] = 1'b0;
    end
  endtask : run_preset

  // ----
  // error acknowledge
  // ----
  task automatic ack_error();
    @(negedge ref_clk);
    control_word[15] = 1'b1;
    @(negedge ref_clk);
    control_word[15] = 1'b0;
  endtask : ack_error
endmodule : esvo_fieldbus_ctrl

// [bench/esvo_core_bench.sv]
// self-checking bench for the position scaling and velocity output core
// assumes the core updates its position and velocity words only on cycle update pulses
`timescale 1ns/1ps
module esvo_core_bench;
  import esvo_pkg::*;
  logic                  ref_clk, rst, cycle_update, sol_fault, warn, ack;
  logic [ESVO_RAW_W-1:0] raw_position;
  logic signed [31:0]    raw_velocity;
  esvo_cfg_type          cfg;
  logic [15:0]           control_word, status_word, vel_short;
  logic [31:0]           pos_word, vel_long, seed, r;
  int                    n_errors, compares, i, k;

  esvo_core u_esvo_core (.REF_CLK(ref_clk), .RST(rst), .RAW_POSITION(raw_position),
    .RAW_VELOCITY(raw_velocity), .CYCLE_UPDATE(cycle_update), .SOL_FAULT(sol_fault),
    .CFG(cfg), .SENSOR_CONTROL_WORD(control_word), .SENSOR_STATUS_WORD(status_word),
    .POSITION_WORD_SECOND(pos_word), .VELOCITY_WORD_SHORT(vel_short),
    .VELOCITY_WORD_LONG(vel_long), .PRESET_WARNING(warn));
  esvo_fieldbus_ctrl u_esvo_fieldbus_ctrl (.ref_clk(ref_clk), .status_word(status_word),
    .control_word(control_word));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  function automatic longint vel_expect(input logic [2:0] u, input longint v);
    case (u)
      3'h0: return v;
      3'h1: return v / 10;
      3'h2: return v / 100;
      3'h3: return v * 60 / 8192;
      default: return v * 60 * (64'sd1 << 30) / (8192 * 3000);
    endcase
  endfunction : vel_expect

  function automatic logic [15:0] short_expect(input logic [2:0] u, input longint e);
    if (u == 3'h4) return 16'(e / 65536);
    if (e > 32767) return 16'h7fff;
    if (e < -32768) return 16'h8000;
    return 16'(e);
  endfunction : short_expect

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic upd(input int n);
    repeat (n)
    begin
      @(negedge ref_clk) cycle_update = 1'b1;
      @(negedge ref_clk) cycle_update = 1'b0;
    end
  endtask : upd

  task automatic chk_vel(input logic [2:0] u, input longint v);
    longint e;
    e = vel_expect(u, v);
    chk("velocity long", 32'(e), vel_long);
    chk("velocity short", {16'h0, short_expect(u, e)}, {16'h0, vel_short});
  endtask : chk_vel

  // preset is taken from the cfg captured at the previous update
  task automatic do_preset(input logic [31:0] v, input logic rel, input logic exp_ack,
                           input logic [31:0] exp_pos);
    cfg.preset_value = v;
    upd(2);
    u_esvo_fieldbus_ctrl.run_preset(rel, ack);
    chk("preset ack", {31'h0, exp_ack}, {31'h0, ack});
    chk("preset warning", {31'h0, !exp_ack}, {31'h0, warn});
    chk("warning status", {31'h0, !exp_ack}, {31'h0, status_word[7]});
    upd(2);
    chk("preset position", exp_pos, pos_word);
    repeat (2) @(negedge ref_clk);
    chk("ack cleared", 32'h0, {31'h0, status_word[12]});
  endtask : do_preset

  task automatic sol_run(input logic compat, input logic [7:0] tol);
    cfg.compat_en = compat;
    cfg.tol_faults = tol;
    upd(2);
    for (k = 0; k <= ((compat) ? tol : 1); k++)
    begin
      @(negedge ref_clk) sol_fault = 1'b1;
      @(negedge ref_clk) sol_fault = 1'b0;
      @(negedge ref_clk);
      chk("sol error", {31'h0, k == ((compat) ? tol : 1)}, {31'h0, status_word[15]});
    end
    upd(1);
    chk("error code", 32'h0000_0f02, pos_word);
    u_esvo_fieldbus_ctrl.ack_error();
    repeat (2) @(negedge ref_clk);
    chk("error cleared", 32'h0, {31'h0, status_word[15]});
  endtask : sol_run

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // ----
  // clock and main sequence
  // ----
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    rst = 1'b1; cycle_update = 1'b0; sol_fault = 1'b0; raw_position = '0; raw_velocity = '0;
    seed = 32'h9; n_errors = 0; compares = 0;
    cfg = '{1'b1, 1'b0, 1'b0, 14'h2000, 30'h2000_0000, 1'b0, 8'h01, 3'h3, 4'h0, 1'b0,
            ESVO_REF_DEFAULT, 32'h0};
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    chk("reset position", 32'h0, pos_word);
    chk("reset status", 32'h0, {16'h0, status_word});
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      r = xorshift();
      raw_position = r[28:0];
      r = xorshift();
      raw_velocity = {12'h000, r[19:0]};
      upd(2);
      chk("native position", {3'h0, raw_position}, pos_word);
      chk_vel(3'h3, longint'(raw_velocity));
    end
    // a cfg change must not touch the words before the next update
    cfg.dir_down = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("held position", {3'h0, raw_position}, pos_word);
    upd(2);
    chk("down position", 32'((30'h2000_0000 - raw_position) % 30'h2000_0000), pos_word);
    $display("test native done");
    cfg = '{1'b1, 1'b1, 1'b0, 14'h0002, 30'h4, 1'b0, 8'h01, 3'h3, 4'h0, 1'b0,
            ESVO_REF_DEFAULT, 32'h0};
    for (i = 3; i < 6; i++)
    begin
      raw_position = 29'(i * 4096);
      upd(2);
      chk("scaled position", 32'(i % 4), pos_word);
    end
    cfg.class4_en = 1'b0;
    upd(2);
    chk("unscaled position", 32'd20480, pos_word);
    cfg = '{1'b1, 1'b1, 1'b0, 14'h2000, 30'd24576, 1'b0, 8'h01, 3'h3, 4'h0, 1'b0,
            ESVO_REF_DEFAULT, 32'h0};
    raw_position = 29'd40967;
    upd(2);
    chk("wrapped position", 32'd16391, pos_word);
    cfg.scale_en = 1'b0;
    $display("test scaling done");
    raw_velocity = 32'sd409600;
    for (i = 0; i < 5; i++)
    begin
      cfg.vel_unit = 3'(i);
      upd(3);
      chk_vel(3'(i), 409600);
    end
    raw_velocity = -32'sd409600;
    upd(3);
    chk_vel(3'h4, -409600);
    for (i = 0; i < 2; i++)
    begin
      raw_velocity = 0;
      cfg.filt_level = 4'h0;
      upd(3);
      cfg.filt_level = 4'ha;
      cfg.filt_dynamic = 1'(i);
      upd(1);
      raw_velocity = 32'sd409600;
      upd(4);
      if (i == 0)
        chk("static filter", 32'h1, {31'h0, vel_long != 0 && vel_long < 32'h1000_0000});
      else
        chk("dynamic bypass", 32'h4000_0000, vel_long);
    end
    // settings above the top intensity run unfiltered
    cfg.filt_level = 4'hb;
    cfg.filt_dynamic = 1'b0;
    upd(1);
    raw_velocity = -32'sd409600;
    upd(2);
    chk_vel(3'h4, -409600);
    cfg.filt_level = 4'h0;
    $display("test velocity done");
    raw_position = 29'd100000;
    do_preset(32'd12345, 1'b0, 1'b1, 32'd12345);
    do_preset(32'hffff_fc18, 1'b1, 1'b1, 32'd11345);
    do_preset(32'h2000_0000, 1'b0, 1'b0, 32'd11345);
    do_preset(32'h0, 1'b0, 1'b1, 32'h0);
    $display("test preset done");
    sol_run(1'b0, 8'h05);
    sol_run(1'b1, 8'h00);
    sol_run(1'b1, 8'h03);
    $display("test sign of life done");
    tally_and_finish();
  end
endmodule : esvo_core_bench
